// >>> logic/uab_autobaud_wake.sv
// Auto-baud overflow detection and wake-on-break logic of the serial receiver
//
// Summary of operation
// - Overflow flag sets when counter passes 16 bits
// - Counter keeps running until fifth rising edge
// - Fifth edge sets receive flag, clears enable
// - Holding register read clears receive flag
// - Software may clear overflow flag directly
// - Overflow clear ignored while enable still set
// - Sleep stops baud generator clocks
// - Wake enable only settable in asynchronous mode
// - Wake enabled suspends reception, watches line
// - Falling receive edge is the wake event
// - Receive flag sets with wake event
// - Holding read clears wake receive condition
// - Rising edge ending break clears wake enable
// - Non-zero character: first low time wakes
`timescale 1ns/1ps
`default_nettype none
module uab_autobaud_wake
  import uab_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  serial_receive_pin_i,
  input  wire logic                  async_mode_i,
  input  wire logic                  sleep_i,
  input  wire uab_sw_ctrl_t          sw_ctrl_i,
  output uab_status_t                status_o,
  output logic [BAUD_CNT_W-1:0]      baud_divisor_pair_o,
  output logic [7:0]                 receive_holding_reg_o
);

  logic rx_rise;
  logic rx_fall;
  logic phase_tick;

  uab_edge_det u_edge (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .pin_i     (serial_receive_pin_i),
    .rise_o    (rx_rise),
    .fall_o    (rx_fall)
  );

  uab_phase_div u_div (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .sleep_i   (sleep_i),
    .tick_o    (phase_tick)
  );

  uab_abd_state_t          state_q;
  uab_abd_state_t          state_d;
  logic [BAUD_CNT_W-1:0]   cnt_q;
  logic [BAUD_CNT_W-1:0]   cnt_d;
  logic [2:0]              edges_q;
  logic [2:0]              edges_d;
  logic                    abd_en_q;
  logic                    abd_en_d;
  logic                    ovf_q;
  logic                    ovf_d;
  logic                    rcv_q;
  logic                    rcv_d;
  logic                    wake_en_q;
  logic                    wake_en_d;
  logic                    wake_low_q;
  logic                    wake_low_d;
  logic                    idle_q;
  logic                    idle_d;
  logic [BAUD_CNT_W-1:0]   div_q;
  logic [BAUD_CNT_W-1:0]   div_d;
  logic [7:0]              hold_q;
  logic [7:0]              hold_d;
  logic                    abd_done;
  logic                    ovf_set;
  logic                    wake_evt;

  // Auto-baud measurement
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    edges_d  = edges_q;
    abd_done = 1'b0;
    ovf_set  = 1'b0;
    div_d    = div_q;
    // Wake watching takes the line; measurement is frozen meanwhile
    if (wake_en_q) begin
      state_d = state_q;
    end else begin
      case (state_q)
        ABD_IDLE: begin
          if (abd_en_q) begin
            state_d = ABD_WAIT_FIRST;
            cnt_d   = BAUD_CNT_RST;
            edges_d = EDGE_RST;
          end
        end
        ABD_WAIT_FIRST: begin
          if (!abd_en_q) begin
            state_d = ABD_IDLE;
          end else if (rx_rise) begin
            state_d = ABD_COUNT;
            edges_d = EDGE_FIRST;
          end
        end
        ABD_COUNT: begin
          if (!abd_en_q) begin
            state_d = ABD_IDLE;
          end else begin
            if (phase_tick) begin
              cnt_d = cnt_q + BAUD_CNT_W'(1);
              if (cnt_q == BAUD_CNT_MAX) begin
                ovf_set = 1'b1;
              end
            end
            if (rx_rise) begin
              edges_d = edges_q + 3'h1;
              if (edges_q + 3'h1 == EDGE_LAST) begin
                abd_done = 1'b1;
                state_d  = ABD_IDLE;
                div_d    = cnt_d;
              end
            end
          end
        end
        default: begin
          state_d = ABD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q <= ABD_IDLE;
      cnt_q   <= BAUD_CNT_RST;
      edges_q <= EDGE_RST;
      div_q   <= BAUD_CNT_RST;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      edges_q <= edges_d;
      div_q   <= div_d;
    end
  end

  // Control and status flags; a hardware set beats a clear, but wake_en_clr still clears wake_low_q on a wake event
  always_comb begin
    wake_evt   = wake_en_q & ~wake_low_q & rx_fall;
    abd_en_d   = abd_en_q;
    ovf_d      = ovf_q;
    rcv_d      = rcv_q;
    wake_en_d  = wake_en_q;
    wake_low_d = wake_low_q;
    hold_d     = hold_q;
    if (sw_ctrl_i.abd_en_set) begin
      abd_en_d = 1'b1;
    end
    if (sw_ctrl_i.abd_en_clr || abd_done) begin
      abd_en_d = 1'b0;
    end
    // Clear only bites once enable is already low, so abort order matters
    if (sw_ctrl_i.ovf_clr && !abd_en_q) begin
      ovf_d = 1'b0;
    end
    if (ovf_set) begin
      ovf_d = 1'b1;
    end
    if (sw_ctrl_i.hold_read) begin
      rcv_d = 1'b0;
    end
    if (abd_done || wake_evt) begin
      rcv_d = 1'b1;
    end
    if (wake_evt) begin
      wake_low_d = 1'b1;
      hold_d     = WAKE_CHAR;
    end
    if (sw_ctrl_i.wake_en_set && async_mode_i) begin
      wake_en_d = 1'b1;
    end
    if (sw_ctrl_i.wake_en_clr) begin
      wake_en_d  = 1'b0;
      wake_low_d = 1'b0;
    end
    if (wake_low_q && rx_rise) begin
      wake_en_d  = 1'b0;
      wake_low_d = 1'b0;
    end
    idle_d = (state_d != ABD_COUNT) & ~wake_low_d;
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      abd_en_q   <= 1'b0;
      ovf_q      <= 1'b0;
      rcv_q      <= 1'b0;
      wake_en_q  <= 1'b0;
      wake_low_q <= 1'b0;
      idle_q     <= 1'b1;
      hold_q     <= HOLD_RST;
    end else begin
      abd_en_q   <= abd_en_d;
      ovf_q      <= ovf_d;
      rcv_q      <= rcv_d;
      wake_en_q  <= wake_en_d;
      wake_low_q <= wake_low_d;
      idle_q     <= idle_d;
      hold_q     <= hold_d;
    end
  end

  // One driver for the whole status word
  assign status_o = '{
    baud_detect_enable:         abd_en_q,
    baud_measure_overflow_flag: ovf_q,
    receive_event_flag:         rcv_q,
    wake_on_break_enable:       wake_en_q,
    receiver_idle_flag:         idle_q
  };
  assign baud_divisor_pair_o                 = div_q;
  assign receive_holding_reg_o               = hold_q;

  // Step sequences for the multi-cycle checks
  sequence s_fifth_edge;
    !wake_en_q && state_q == ABD_COUNT && abd_en_q && rx_rise && edges_q == 3'h4;
  endsequence

  sequence s_wrap;
    !wake_en_q && state_q == ABD_COUNT && abd_en_q && phase_tick && cnt_q == BAUD_CNT_MAX;
  endsequence

  sequence s_wake_edge;
    wake_en_q && !wake_low_q && rx_fall;
  endsequence

  a_ovf_on_wrap: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_wrap |=> ovf_q && cnt_q == BAUD_CNT_RST)
    else $error("overflow flag not set on counter wrap");

  a_count_runs_on: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == ABD_COUNT && abd_en_q && !wake_en_q && phase_tick && !rx_rise
      |=> state_q == ABD_COUNT && cnt_q == $past(cnt_q) + BAUD_CNT_W'(1))
    else $error("counter stopped before fifth edge");

  a_fifth_edge_done: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_fifth_edge |=> !abd_en_q && rcv_q && state_q == ABD_IDLE)
    else $error("fifth edge did not finish measurement");

  a_read_clears: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    rcv_q && sw_ctrl_i.hold_read && !abd_done && !wake_evt |=> !rcv_q)
    else $error("holding read did not clear receive flag");

  a_ovf_clr_ok: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ovf_q && !abd_en_q && sw_ctrl_i.ovf_clr && !ovf_set |=> !ovf_q)
    else $error("overflow clear ignored with enable low");

  a_ovf_clr_blocked: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ovf_q && abd_en_q && sw_ctrl_i.ovf_clr |=> ovf_q [*2])
    else $error("overflow cleared while enable set");

  a_sleep_no_tick: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    sleep_i |-> !phase_tick)
    else $error("baud tick while sleeping");

  a_wake_async_only: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $rose(wake_en_q) |-> $past(async_mode_i) && $past(sw_ctrl_i.wake_en_set))
    else $error("wake enable set outside async mode");

  a_wake_freezes: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    wake_en_q |=> $stable(edges_q) && $stable(div_q))
    else $error("measurement moved while wake enabled");

  a_wake_flag: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_wake_edge |=> rcv_q && wake_low_q && !idle_q)
    else $error("wake edge did not raise receive flag");

  a_break_end: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    wake_low_q && rx_rise |=> !wake_en_q && !wake_low_q ##1 idle_q || state_q == ABD_COUNT)
    else $error("break end did not clear wake enable");

  a_sleep_frozen: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    sleep_i && state_q == ABD_COUNT |=> $stable(cnt_q))
    else $error("baud counter moved while sleeping");

  a_first_rise: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == ABD_WAIT_FIRST && abd_en_q && !wake_en_q && rx_rise
      |=> state_q == ABD_COUNT && edges_q == EDGE_FIRST)
    else $error("first rising edge did not start counting");

  a_abort_idle: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q != ABD_IDLE && !abd_en_q && !wake_en_q |=> state_q == ABD_IDLE)
    else $error("measurement kept running with enable low");

  a_rcv_stands: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    rcv_q && !sw_ctrl_i.hold_read |=> rcv_q)
    else $error("receive flag dropped without a holding read");

  a_idle_busy: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == ABD_COUNT || wake_low_q |-> !idle_q)
    else $error("idle flag high while busy");

endmodule
`default_nettype wire

// >>> logic/uab_pkg.sv
// Shared constants and carrier types for the auto-baud and wake-on-break block
package uab_pkg;

  localparam int unsigned          CLK_FREQ_HZ     = 100_000_000;
  localparam int unsigned          BAUD_CNT_W      = 16;
  localparam logic [BAUD_CNT_W-1:0] BAUD_CNT_MAX   = 16'hFFFF;
  localparam logic [BAUD_CNT_W-1:0] BAUD_CNT_RST   = 16'h0000;
  localparam logic [2:0]           EDGE_FIRST      = 3'h1;
  localparam logic [2:0]           EDGE_LAST       = 3'h5;
  localparam logic [2:0]           EDGE_RST        = 3'h0;
  // Fast phase keeps a full 16-bit wrap inside a short run
  localparam int unsigned          PHASE_DIV       = 2;
  localparam int unsigned          PHASE_CNT_W     = 1;
  localparam logic [PHASE_CNT_W-1:0] PHASE_CNT_RST = 1'h0;
  localparam logic [PHASE_CNT_W-1:0] PHASE_CNT_TOP = PHASE_CNT_W'(PHASE_DIV - 1);
  localparam logic [7:0]           HOLD_RST        = 8'h00;
  localparam logic [7:0]           WAKE_CHAR       = 8'h00;

  typedef struct packed {
    logic abd_en_set;
    logic abd_en_clr;
    logic wake_en_set;
    logic wake_en_clr;
    logic ovf_clr;
    logic hold_read;
  } uab_sw_ctrl_t;

  typedef struct packed {
    logic baud_detect_enable;
    logic baud_measure_overflow_flag;
    logic receive_event_flag;
    logic wake_on_break_enable;
    logic receiver_idle_flag;
  } uab_status_t;

  typedef enum logic [1:0] {
    ABD_IDLE,
    ABD_WAIT_FIRST,
    ABD_COUNT
  } uab_abd_state_t;

endpackage

// >>> logic/uab_edge_det.sv
// Rising and falling edge detector for the synchronous receive pin
`timescale 1ns/1ps
`default_nettype none
module uab_edge_det
  import uab_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic srst_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);

  logic pin_q;
  logic pin_d;

  always_comb begin
    pin_d = pin_i;
  end

  // Line idles high, so reset to mark avoids a false edge
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign rise_o = pin_i & ~pin_q;
  assign fall_o = ~pin_i & pin_q;

endmodule
`default_nettype wire

// >>> logic/uab_phase_div.sv
// Instruction-phase enable divider, frozen while sleeping
`timescale 1ns/1ps
`default_nettype none
module uab_phase_div
  import uab_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic srst_i,
  input  wire logic sleep_i,
  output logic      tick_o
);

  logic [PHASE_CNT_W-1:0] cnt_q;
  logic [PHASE_CNT_W-1:0] cnt_d;
  logic                   tick_q;
  logic                   tick_d;

  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (!sleep_i) begin
      if (cnt_q == PHASE_CNT_TOP) begin
        cnt_d  = PHASE_CNT_RST;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + PHASE_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_q  <= PHASE_CNT_RST;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q & ~sleep_i;

endmodule
`default_nettype wire

// >>> tb/uab_remote_tx.sv
// Remote asynchronous transmitter model driving the receive line
`timescale 1ns/1ps
`default_nettype none
module uab_remote_tx (
  input  wire logic ref_clk_i,
  output logic      rx_o
);
  // Line idles high between frames
  initial rx_o = 1'b1;

  // Caller sits at a falling edge; level held n clocks
  task automatic level(input logic v, input int n);
    rx_o = v;
    repeat (n) @(negedge ref_clk_i);
  endtask

  task automatic pulse(input int lo, input int hi);
    level(1'b0, lo);
    level(1'b1, hi);
  endtask

  // Start bit, eight data bits lsb first, stop bit
  task automatic send_char(input logic [7:0] c, input int bt);
    level(1'b0, bt);
    for (int i = 0; i < 8; i++) begin
      level(c[i], bt);
    end
    level(1'b1, bt);
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking testbench for the auto-baud and wake-on-break block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import uab_pkg::*;
  localparam int BT = 16;
  logic          ref_clk;
  logic          srst;
  logic          rx;
  logic          async_mode;
  logic          sleep;
  uab_sw_ctrl_t  sw_ctrl;
  uab_status_t   st;
  uab_status_t   m;
  logic [15:0]   div;
  logic [7:0]    hold;
  int            mismatches;
  int            n_compared;
  int            lo;
  int            hi;

  uab_remote_tx uab_remote_tx_i (.ref_clk_i(ref_clk), .rx_o(rx));
  uab_autobaud_wake uab_autobaud_wake_i (
    .ref_clk_i(ref_clk), .srst_i(srst), .serial_receive_pin_i(rx),
    .async_mode_i(async_mode), .sleep_i(sleep), .sw_ctrl_i(sw_ctrl),
    .status_o(st), .baud_divisor_pair_o(div), .receive_holding_reg_o(hold));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] lo_v, input logic [15:0] hi_v);
    n_compared++;
    if ($isunknown(got) || got < lo_v || got > hi_v) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h..%h", $time, got, lo_v, hi_v);
    end
  endtask

  // Whole status word against the bench model
  task automatic chk_st;
    chk(16'(st), 16'(m), 16'(m));
  endtask

  // One-cycle strobe, then let the answer land
  task automatic strobe(input uab_sw_ctrl_t v);
    sw_ctrl = v;
    @(negedge ref_clk);
    sw_ctrl = '0;
    repeat (2) @(negedge ref_clk);
  endtask

  initial begin
    repeat (150000) @(posedge ref_clk);
    mismatches++;
    complete_run();
  end

  initial begin
    void'($urandom(27925));
    srst = 1'b1; async_mode = 1'b0; sleep = 1'b0; sw_ctrl = '0;
    mismatches = 0; n_compared = 0;
    m = '0; m.receiver_idle_flag = 1'b1;
    repeat (12) @(negedge ref_clk);
    srst = 1'b0;
    @(negedge ref_clk);
    chk_st();
    chk(16'(div), 16'h0000, 16'h0000);
    // Measurement with Sleep in mid-count; frozen ticks must not count
    lo = 5 + $urandom % 20;
    hi = 10 + $urandom % 60;
    strobe(6'h20);
    m.baud_detect_enable = 1'b1;
    chk_st();
    uab_remote_tx_i.pulse(lo, hi);
    sleep = 1'b1;
    repeat (400) @(negedge ref_clk);
    sleep = 1'b0;
    repeat (4) uab_remote_tx_i.pulse(lo, hi);
    m.baud_detect_enable = 1'b0;
    m.receive_event_flag = 1'b1;
    chk_st();
    chk(div, 16'(4 * (lo + hi) / PHASE_DIV - 1), 16'(4 * (lo + hi) / PHASE_DIV + 1));
    strobe(6'h01);
    m.receive_event_flag = 1'b0;
    chk_st();
    // Abort in mid-count: clear enable first, then overflow
    strobe(6'h20);
    uab_remote_tx_i.pulse(4, 8);
    strobe(6'h10);
    strobe(6'h02);
    repeat (4) uab_remote_tx_i.pulse(4, 8);
    chk_st();
    // Overflow: four quick rises, long gap, fifth rise
    strobe(6'h20);
    m.baud_detect_enable = 1'b1;
    repeat (4) uab_remote_tx_i.pulse(10, 10);
    // Gap sized so the count wraps once and lands near 22h
    uab_remote_tx_i.level(1'b1, int'(PHASE_DIV) * 65570 - 80);
    m.baud_measure_overflow_flag = 1'b1;
    m.receiver_idle_flag = 1'b0;
    chk_st();
    strobe(6'h02);
    chk_st();
    uab_remote_tx_i.pulse(10, 10);
    m.baud_detect_enable = 1'b0;
    m.receive_event_flag = 1'b1;
    m.receiver_idle_flag = 1'b1;
    chk_st();
    chk(div, 16'h0021, 16'h0023);
    strobe(6'h02);
    m.baud_measure_overflow_flag = 1'b0;
    chk_st();
    strobe(6'h01);
    m.receive_event_flag = 1'b0;
    // Wake enable refused outside asynchronous mode
    strobe(6'h08);
    chk_st();
    async_mode = 1'b1;
    chk(16'(st.receiver_idle_flag), 16'h0001, 16'h0001);
    strobe(6'h08);
    m.wake_on_break_enable = 1'b1;
    chk_st();
    // Thirteen-bit break while sleeping
    sleep = 1'b1;
    uab_remote_tx_i.level(1'b0, 6 * BT);
    m.receive_event_flag = 1'b1;
    m.receiver_idle_flag = 1'b0;
    chk_st();
    chk(16'(hold), 16'h0000, 16'h0000);
    uab_remote_tx_i.level(1'b0, 7 * BT);
    uab_remote_tx_i.level(1'b1, 3);
    m.wake_on_break_enable = 1'b0;
    m.receiver_idle_flag = 1'b1;
    chk_st();
    sleep = 1'b0;
    strobe(6'h01);
    m.receive_event_flag = 1'b0;
    chk_st();
    // Non-zero character: only the first low time wakes
    strobe(6'h08);
    uab_remote_tx_i.send_char(8'(1 + $urandom % 255) | 8'h01, BT);
    m.receive_event_flag = 1'b1;
    chk_st();
    strobe(6'h01);
    complete_run();
  end
endmodule
`default_nettype wire
